// ---- adq_pkg.sv ----
// adq_pkg: constants, register map and types for the acquisition sequencer
// assumes a 40 MHz system clock and a 32-bit classic wishbone register bus
package adq_pkg;
  // ---------------------------------------------------------------
  // clock and timebase periods
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned TB20M_NS = 50;
  localparam int unsigned TB1M_NS = 1000;
  localparam int unsigned TB100K_NS = 10000;
  localparam int unsigned TB10K_NS = 100000;
  localparam int unsigned TB1K_NS = 1000000;
  localparam int unsigned TB100_NS = 10000000;
  localparam int unsigned TB20M_CYC = TB20M_NS / CLK_NS;
  localparam int unsigned TB1M_CYC = TB1M_NS / CLK_NS;
  localparam int unsigned TB100K_CYC = TB100K_NS / CLK_NS;
  localparam int unsigned TB10K_CYC = TB10K_NS / CLK_NS;
  localparam int unsigned TB1K_CYC = TB1K_NS / CLK_NS;
  localparam int unsigned TB100_CYC = TB100_NS / CLK_NS;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_TB = 8'h08;
  localparam logic [7:0] REG_IVAL = 8'h0c;
  localparam logic [7:0] REG_TOTAL = 8'h10;
  localparam logic [7:0] REG_POST = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] REG_DATA = 8'h1c;
  localparam logic [7:0] REG_FILL = 8'h20;
  localparam logic [7:0] REG_AICFG = 8'h24;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CTRL_HWSTART = 0;
  localparam int CTRL_GATE = 1;
  localparam int CTRL_CONV = 2;
  localparam int CTRL_PRE = 4;
  localparam int CTRL_CONT = 5;
  localparam int CTRL_ALTSRC = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [3:0] TB_EXT = 4'h0;
  localparam logic [3:0] TB_1M = 4'h1;
  localparam logic [3:0] TB_100K = 4'h2;
  localparam logic [3:0] TB_10K = 4'h3;
  localparam logic [3:0] TB_1K = 4'h4;
  localparam logic [3:0] TB_100 = 4'h5;
  localparam logic [3:0] TB_20M = 4'hd;
  localparam logic [3:0] TB_RST = 4'h1;
  localparam logic [24:0] IVAL_RST = 25'h0000002;
  localparam logic [30:0] TOTAL_RST = 31'h00000003;
  localparam logic [30:0] POST_RST = 31'h00000003;
  localparam int AI_MODE = 0;
  localparam int AI_POL = 1;
  localparam int AI_RANGE = 2;
  localparam logic [5:0] AI_RST = 6'h28;
  localparam int SB_DONE = 0;
  localparam int SB_ACTIVE = 1;
  localparam int SB_ARMED = 2;
  localparam int SB_TRIG = 3;
  localparam int AW = 8;
  localparam int unsigned DEPTH = 256;
  typedef logic [AW-1:0] adq_ptr_t;
  typedef logic [18:0] adq_pre_t;
  typedef enum logic [2:0] {
    S_IDLE, S_ARMED, S_RUN, S_POST, S_DRAIN, S_DONE
  } adq_state_t;
endpackage

// ---- adq_seq.sv ----
// adq_seq: single-channel acquisition sequencer with wishbone registers
// assumes inputs synchronous to clk_i and an adc that answers each
// convert_o pulse with one adc_valid_i pulse
//
// Notes on behaviour
// - resets to software start, internal interval timing
// - pretrigger runs until stop, then post count
// - internal timing may add one extra sample
// - external timing may add one as well
// - record holds pre-stop samples then post samples
// - total count register accepts 3 to 2^31-1
// - codes 1..5 pick 1M..100Hz timebases
// - code 0 counts an external clock
// - code -3 picks the 20 MHz timebase
// - code 0 defaults to connector input edges
// - external conversion ignores timebase selection
// - continuous mode ignores total until stopped
// - each record word is one 16-bit result
// - input config resets differential, 10 V, bipolar
// - finished circular record reads oldest first
// - interval equals count times timebase period
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module adq_seq #(
  parameter int unsigned TB1K_CYC = adq_pkg::TB1K_CYC,
  parameter int unsigned TB100_CYC = adq_pkg::TB100_CYC
) (
  input wire logic clk_i, // 40 MHz system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic ce_i, // clock enable, low freezes
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [15:0] adc_data_i, // conversion result
  input wire logic adc_valid_i, // result strobe
  input wire logic ext_start_i, // hw start trigger
  input wire logic ext_stop_i, // pretrigger stop trigger
  input wire logic gate_i, // external gate level
  input wire logic ext_conversion_strobe_n_i, // ext convert, low
  input wire logic programmable_connector_input_i, // timebase pin
  input wire logic ext_timebase_i, // alternate timebase
  output logic convert_o, // conversion strobe
  output logic active_o, // acquisition running
  output logic done_o, // record complete
  output logic ai_mode_o, // 0 differential
  output logic ai_polarity_o, // 0 bipolar
  output logic [3:0] ai_range_o // range code
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d, rmux, be, wv;
  logic [adq_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [3:0] tb_q, tb_d;
  logic [24:0] ival_q, ival_d;
  logic [30:0] tot_q, tot_d, postc_q, postc_d;
  logic [5:0] ai_q, ai_d;
  logic wr, rd_take, start_w, stop_w;
  adq_pkg::adq_state_t st_q, st_d;
  adq_pkg::adq_pre_t pre_q, pre_d, per;
  logic [24:0] iv_q, iv_d;
  logic conv_q, pend_q, pend_d, wrap_q, wrap_d, done_q, done_d;
  logic trig_q, trig_d, act_q, act_d;
  logic src_q, strn_q, stop_q, hst_q;
  logic [30:0] fill_q, fill_d, post_q, post_d;
  adq_pkg::adq_ptr_t wptr_q, wptr_d, rptr_q, rptr_d, lim, wnext;
  logic run, ext_conv, gate_ok, tick, conv, samp, tb_ext;
  logic src, src_rise, strn_fall, stop_rise, hst_rise;
  logic [15:0] mem [adq_pkg::DEPTH];

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  // writes land on the ack edge, so the master sees them then
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign rd_take = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;
  assign start_w = wr && wb_adr_i == adq_pkg::REG_CMD && wb_sel_i[0]
                   && wb_dat_i[adq_pkg::CMD_START];
  assign stop_w = wr && wb_adr_i == adq_pkg::REG_CMD && wb_sel_i[0]
                  && wb_dat_i[adq_pkg::CMD_STOP];
  assign be = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wv = (wb_dat_i & be) | (rmux & ~be);

  // read mux, unmapped and write-only addresses read zero
  always_comb begin
    rmux = 32'h0;
    if (wb_adr_i == adq_pkg::REG_CTRL) begin
      rmux[adq_pkg::CTRL_W-1:0] = ctrl_q;
    end else if (wb_adr_i == adq_pkg::REG_TB) begin
      rmux[3:0] = tb_q;
    end else if (wb_adr_i == adq_pkg::REG_IVAL) begin
      rmux[24:0] = ival_q;
    end else if (wb_adr_i == adq_pkg::REG_TOTAL) begin
      rmux[30:0] = tot_q;
    end else if (wb_adr_i == adq_pkg::REG_POST) begin
      rmux[30:0] = postc_q;
    end else if (wb_adr_i == adq_pkg::REG_STAT) begin
      rmux[adq_pkg::SB_DONE] = done_q;
      rmux[adq_pkg::SB_ACTIVE] = act_q;
      rmux[adq_pkg::SB_ARMED] = st_q == adq_pkg::S_ARMED;
      rmux[adq_pkg::SB_TRIG] = trig_q;
    end else if (wb_adr_i == adq_pkg::REG_DATA) begin
      rmux[15:0] = mem[rptr_q];
    end else if (wb_adr_i == adq_pkg::REG_FILL) begin
      rmux[30:0] = fill_q;
    end else if (wb_adr_i == adq_pkg::REG_AICFG) begin
      rmux[5:0] = ai_q;
    end
  end

  // configuration registers and bus answer
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    dat_d = rd_take ? rmux : dat_q;
    ctrl_d = ctrl_q;
    tb_d = tb_q;
    ival_d = ival_q;
    tot_d = tot_q;
    postc_d = postc_q;
    ai_d = ai_q;
    if (wr) begin
      if (wb_adr_i == adq_pkg::REG_CTRL) begin
        ctrl_d = wv[adq_pkg::CTRL_W-1:0];
      end else if (wb_adr_i == adq_pkg::REG_TB) begin
        tb_d = wv[3:0];
      end else if (wb_adr_i == adq_pkg::REG_IVAL) begin
        ival_d = wv[24:0];
      end else if (wb_adr_i == adq_pkg::REG_TOTAL) begin
        tot_d = wv[30:0];
      end else if (wb_adr_i == adq_pkg::REG_POST) begin
        postc_d = wv[30:0];
      end else if (wb_adr_i == adq_pkg::REG_AICFG) begin
        ai_d = wv[5:0];
      end
    end
  end

  // reset defaults: software start, no gate, internal timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      ctrl_q <= adq_pkg::CTRL_RST;
      tb_q <= adq_pkg::TB_RST;
      ival_q <= adq_pkg::IVAL_RST;
      tot_q <= adq_pkg::TOTAL_RST;
      postc_q <= adq_pkg::POST_RST;
      ai_q <= adq_pkg::AI_RST;
    end else if (ce_i) begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      ctrl_q <= ctrl_d;
      tb_q <= tb_d;
      ival_q <= ival_d;
      tot_q <= tot_d;
      postc_q <= postc_d;
      ai_q <= ai_d;
    end
  end

  // ---------------------------------------------------------------
  // timebase and conversion timing
  // ---------------------------------------------------------------
  assign ext_conv = ctrl_q[adq_pkg::CTRL_CONV +: 2] != 2'h0;
  assign gate_ok = ~ctrl_q[adq_pkg::CTRL_GATE] | gate_i;
  assign run = st_q == adq_pkg::S_RUN || st_q == adq_pkg::S_POST;
  assign tb_ext = tb_q == adq_pkg::TB_EXT;
  assign src = ctrl_q[adq_pkg::CTRL_ALTSRC] ? ext_timebase_i
               : programmable_connector_input_i;
  assign src_rise = src & ~src_q;
  assign strn_fall = strn_q & ~ext_conversion_strobe_n_i;
  assign stop_rise = ext_stop_i & ~stop_q;
  assign hst_rise = ext_start_i & ~hst_q;

  // prescaler terminal count per timebase code
  always_comb begin
    case (tb_q)
      adq_pkg::TB_20M: per = 19'(adq_pkg::TB20M_CYC - 1);
      adq_pkg::TB_1M: per = 19'(adq_pkg::TB1M_CYC - 1);
      adq_pkg::TB_100K: per = 19'(adq_pkg::TB100K_CYC - 1);
      adq_pkg::TB_10K: per = 19'(adq_pkg::TB10K_CYC - 1);
      adq_pkg::TB_1K: per = 19'(TB1K_CYC - 1);
      adq_pkg::TB_100: per = 19'(TB100_CYC - 1);
      default: per = 19'(adq_pkg::TB1M_CYC - 1);
    endcase
  end

  // external edges stand in for the prescaler under code 0
  assign tick = tb_ext ? src_rise : pre_q == per;
  // ext conversion bypasses prescaler and interval entirely
  assign conv = run && (ext_conv ? strn_fall
                : gate_ok && tick && iv_q == 25'h0);
  assign samp = adc_valid_i && pend_q && (run
                || st_q == adq_pkg::S_DRAIN);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // beyond DEPTH words the record keeps only the newest DEPTH samples
  always_comb begin
    if (ctrl_q[adq_pkg::CTRL_CONT] || tot_q > 31'(adq_pkg::DEPTH)) begin
      lim = adq_pkg::adq_ptr_t'(adq_pkg::DEPTH - 1);
    end else begin
      lim = adq_pkg::adq_ptr_t'(tot_q - 31'h1);
    end
    wnext = wptr_q == lim ? '0 : wptr_q + 1'b1;
  end

  // state, counters and record pointers
  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    iv_d = iv_q;
    pend_d = pend_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    wrap_d = wrap_q;
    fill_d = fill_q;
    post_d = post_q;
    trig_d = trig_q;
    done_d = done_q;
    // a gate held low suspends the interval count
    if (!run) begin
      pre_d = '0;
      iv_d = ival_q - 25'h1;
    end else if (gate_ok && !ext_conv) begin
      pre_d = (tb_ext || pre_q == per) ? '0 : pre_q + 1'b1;
      if (tick) begin
        iv_d = iv_q == 25'h0 ? ival_q - 25'h1 : iv_q - 25'h1;
      end
    end
    if (samp) begin
      pend_d = 1'b0;
      wptr_d = wnext;
      wrap_d = wrap_q | wnext == '0;
      fill_d = fill_q + 31'h1;
    end
    if (conv) begin
      pend_d = 1'b1;
    end
    case (st_q)
      adq_pkg::S_ARMED: begin
        if (hst_rise) begin
          st_d = adq_pkg::S_RUN;
        end
      end
      adq_pkg::S_RUN: begin
        if (ctrl_q[adq_pkg::CTRL_PRE] && stop_rise) begin
          st_d = adq_pkg::S_POST;
          trig_d = 1'b1;
          post_d = '0;
        end else if (samp && !ctrl_q[adq_pkg::CTRL_CONT]
                     && !ctrl_q[adq_pkg::CTRL_PRE]
                     && fill_q + 31'h1 == tot_q) begin
          st_d = adq_pkg::S_DONE;
        end
      end
      adq_pkg::S_POST: begin
        if (samp) begin
          post_d = post_q + 31'h1;
          if (post_q + 31'h1 == postc_q) begin
            // a conversion started in the same cycle adds one sample
            st_d = conv ? adq_pkg::S_DRAIN
                   : adq_pkg::S_DONE;
          end
        end
      end
      adq_pkg::S_DRAIN: begin
        if (samp) begin
          st_d = adq_pkg::S_DONE;
        end
      end
      default: ;
    endcase
    // software start from idle or after a finished record
    if (start_w && (st_q == adq_pkg::S_IDLE
                    || st_q == adq_pkg::S_DONE)) begin
      st_d = ctrl_q[adq_pkg::CTRL_HWSTART] ? adq_pkg::S_ARMED
             : adq_pkg::S_RUN;
      wptr_d = '0;
      rptr_d = '0;
      wrap_d = 1'b0;
      fill_d = '0;
      trig_d = 1'b0;
      pend_d = 1'b0;
      done_d = 1'b0;
    end
    if (stop_w) begin
      st_d = adq_pkg::S_IDLE;
      pend_d = 1'b0;
      done_d = 1'b0;
    end
    // a stop arriving in the same cycle wins over the set
    if (st_d == adq_pkg::S_DONE && st_q != adq_pkg::S_DONE) begin
      done_d = 1'b1;
      rptr_d = wrap_d ? wptr_d : '0;
    end else if (rd_take && wb_adr_i == adq_pkg::REG_DATA) begin
      rptr_d = rptr_q == lim ? '0 : rptr_q + 1'b1;
    end
    act_d = st_d == adq_pkg::S_RUN || st_d == adq_pkg::S_POST
            || st_d == adq_pkg::S_DRAIN;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= adq_pkg::S_IDLE;
      pre_q <= '0;
      iv_q <= '0;
      conv_q <= 1'b0;
      pend_q <= 1'b0;
      wptr_q <= '0;
      rptr_q <= '0;
      wrap_q <= 1'b0;
      fill_q <= '0;
      post_q <= '0;
      trig_q <= 1'b0;
      done_q <= 1'b0;
      act_q <= 1'b0;
      src_q <= 1'b0;
      strn_q <= 1'b1;
      stop_q <= 1'b0;
      hst_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      pre_q <= pre_d;
      iv_q <= iv_d;
      conv_q <= conv;
      pend_q <= pend_d;
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      wrap_q <= wrap_d;
      fill_q <= fill_d;
      post_q <= post_d;
      trig_q <= trig_d;
      done_q <= done_d;
      act_q <= act_d;
      src_q <= src;
      strn_q <= ext_conversion_strobe_n_i;
      stop_q <= ext_stop_i;
      hst_q <= ext_start_i;
    end
  end

  // record memory, one result per word in acquisition order
  always_ff @(posedge clk_i) begin
    if (ce_i && samp) begin
      mem[wptr_q] <= adc_data_i;
    end
  end

  // outputs, each a flop
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign convert_o = conv_q;
  assign active_o = act_q;
  assign done_o = done_q;
  assign ai_mode_o = ai_q[adq_pkg::AI_MODE];
  assign ai_polarity_o = ai_q[adq_pkg::AI_POL];
  assign ai_range_o = ai_q[adq_pkg::AI_RANGE +: 4];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence post_last;
    st_q == adq_pkg::S_POST && samp && post_q + 31'h1 == postc_q;
  endsequence
  sequence drain_done;
    st_q == adq_pkg::S_DRAIN && samp && !stop_w;
  endsequence

  a_reset_defaults: assert property ($past(rst_i) |->
    ctrl_q == adq_pkg::CTRL_RST && ai_q == adq_pkg::AI_RST)
    else $error("defaults wrong after reset");
  a_pre_stops: assert property (post_last and ##0 !stop_w
    |=> st_q == adq_pkg::S_DONE || st_q == adq_pkg::S_DRAIN)
    else $error("post count did not end run");
  a_drain_one: assert property (drain_done
    |=> st_q == adq_pkg::S_DONE && done_o)
    else $error("drain took more than one sample");
  a_tb_20m: assert property (tb_q == adq_pkg::TB_20M |->
    per == 19'(adq_pkg::TB20M_CYC - 1))
    else $error("20 MHz timebase wrong");
  a_tb_ext: assert property (run && tb_ext && !ext_conv && gate_ok
    && src_rise && iv_q == 25'h0 |=> convert_o)
    else $error("external timebase edge lost");
  a_conv_ext: assert property (run && ext_conv && !strn_fall
    |=> !convert_o)
    else $error("convert without external strobe");
  a_cont_runs: assert property (st_q == adq_pkg::S_RUN
    && ctrl_q[adq_pkg::CTRL_CONT] && !ctrl_q[adq_pkg::CTRL_PRE]
    |=> st_q != adq_pkg::S_DONE)
    else $error("continuous run stopped on count");
  a_iv_reload: assert property (run && !ext_conv && gate_ok && tick
    && iv_q == 25'h0 |=> iv_q == ival_q - 25'h1 && convert_o)
    else $error("interval reload wrong");
  a_done_flag: assert property ($rose(st_q == adq_pkg::S_DONE)
    |-> done_o ##1 done_o || st_q != adq_pkg::S_DONE)
    else $error("done flag missing");
  a_oldest_first: assert property ($rose(st_q == adq_pkg::S_DONE)
    && wrap_q |-> rptr_q == wptr_q)
    else $error("record not rotated");
  a_word_width: assert property (ack_q && !wb_we_i
    && wb_adr_i == adq_pkg::REG_DATA |-> wb_dat_o[31:16] == 16'h0)
    else $error("data word wider than 16 bits");
endmodule

// ---- adq_front_model.sv ----
// adq_front_model: behavioural converter front end for the sequencer
// assumes one result strobe is owed for every convert pulse seen
`timescale 1ns/1ps
module adq_front_model (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic convert_i, // conversion strobe from sequencer
  input wire logic slow_i, // 1 answers three cycles late
  output logic [15:0] data_o, // conversion result
  output logic valid_o // result strobe
);
  // ---------------------------------------------------------------
  // conversion engine
  // ---------------------------------------------------------------
  logic [15:0] val_q;
  logic [2:0] wait_q;
  // results count up so that order and loss show in the record
  always_ff @(posedge clk_i) begin
    valid_o <= 1'b0;
    if (rst_i) begin
      val_q <= 16'h1000;
      wait_q <= 3'h0;
      data_o <= 16'h5555;
    end else begin
      if (convert_i) begin
        wait_q <= slow_i ? 3'h3 : 3'h1;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
      if (wait_q == 3'h1) begin
        valid_o <= 1'b1;
        data_o <= val_q;
        val_q <= val_q + 16'h1;
      end else begin
        data_o <= ~data_o; // bus released: last result and its inverse alternate
      end
    end
  end
endmodule

// ---- test_adc_acquisition_sequencer.sv ----
// test_adc_acquisition_sequencer: self-checking bench for adq_seq
// assumes the 40 MHz clock and short slow-timebase parameters 8 and 16
`timescale 1ns/1ps
module test_adc_acquisition_sequencer;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dw = 32'h0, rdat, q, q0;
  logic ack, adc_valid, slow = 1'b0, conv, active_o, done_o;
  logic [15:0] adc_data, last_v;
  logic start = 1'b0, stop = 1'b0, pin = 1'b0, strobe_n = 1'b1;
  logic gate = 1'b1, alt = 1'b0;
  int nval = 0, nconv = 0, n0;
  logic ai_mode, ai_pol, stop_seen = 1'b0;
  logic [3:0] ai_range;
  int err_count = 0, num_checks = 0, cyc_n = 0, npost = 0, c, fr = 0;
  logic [7:0] ra [7] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h3c};
  logic [31:0] rv [7] = '{0, 1, 2, 3, 3, 32'h28, 0};
  logic [3:0] tc [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hd, 4'h0};
  int te [7] = '{80, 800, 8000, 16, 32, 4, 20};

  initial forever #12.5 clk_i = ~clk_i;

  adq_seq #(.TB1K_CYC(8), .TB100_CYC(16)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
    .wb_dat_o(rdat), .wb_ack_o(ack), .adc_data_i(adc_data),
    .adc_valid_i(adc_valid), .ext_start_i(start), .ext_stop_i(stop),
    .gate_i(gate), .ext_conversion_strobe_n_i(strobe_n),
    .programmable_connector_input_i(pin), .ext_timebase_i(alt),
    .convert_o(conv), .active_o(active_o), .done_o(done_o),
    .ai_mode_o(ai_mode), .ai_polarity_o(ai_pol), .ai_range_o(ai_range));

  adq_front_model adc (.clk_i(clk_i), .rst_i(rst_i), .convert_i(conv),
    .slow_i(slow), .data_o(adc_data), .valid_o(adc_valid));

  // free-running connector pin (edge every 10) and strobe (every 12)
  always @(posedge clk_i) begin
    fr <= fr + 1;
    pin <= ((fr / 5) % 2) == 1;
    strobe_n <= (fr % 12) != 0;
    alt <= (fr % 8) < 4; // alternate source, edge every 8
    if (adc_valid) nval++;
    if (conv) nconv++;
    if (adc_valid && stop_seen) npost++;
    if (adc_valid) last_v <= adc_data;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      err_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // classic cycle: hold until ack is sampled, then release
  // a missing ack is caught by the bench-wide cycle ceiling
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task iv(output int cc);
    int n;
    n = 0;
    cc = 0;
    do begin @(posedge clk_i); n++; end while (conv !== 1'b1 && n < 9000);
    do begin @(posedge clk_i); cc++; end while (conv !== 1'b1 && cc < 9000);
  endtask

  task wdone;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (done_o !== 1'b1 && n < 9000);
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wb(0, ra[i], 0);
      chk(q, rv[i]);
    end
    chk({ai_range, ai_pol, ai_mode}, 32'h28);
    // plain run: 1 MHz timebase, interval 2, four samples
    wb(1, 8'h10, 4);
    wb(1, 8'h00, 1);
    iv(c);
    chk(c, 80);
    wdone();
    wb(0, 8'h18, 0);
    chk(q, 1);
    wb(0, 8'h20, 0);
    chk(q, 4);
    for (int i = 0; i < 4; i++) begin
      wb(0, 8'h1c, 0);
      chk(q, 32'h1000 + i);
    end
    // every timebase code, code 0 counting connector pin edges
    for (int i = 0; i < 7; i++) begin
      wb(1, 8'h00, 2);
      wb(1, 8'h08, tc[i]);
      wb(1, 8'h00, 1);
      iv(c);
      chk(c, te[i]);
    end
    // alternate code-0 source replaces the connector pin
    wb(1, 8'h00, 2);
    wb(1, 8'h04, 32'h40);
    wb(1, 8'h00, 1);
    iv(c);
    chk(c, 16);
    // external conversion strobe overrides the slow timebase
    wb(1, 8'h00, 2);
    wb(1, 8'h08, 5);
    wb(1, 8'h04, 32'h4);
    wb(1, 8'h00, 1);
    iv(c);
    chk(c, 12);
    // hardware start waits armed for the start edge
    wb(1, 8'h00, 2);
    wb(1, 8'h08, 4'hd);
    wb(1, 8'h04, 1);
    wb(1, 8'h00, 1);
    wb(0, 8'h18, 0);
    chk(q, 4);
    start <= 1'b1;
    repeat (4) @(posedge clk_i);
    start <= 1'b0;
    chk(active_o, 1);
    // gate low holds the interval count, no strobes at all
    wb(1, 8'h00, 2);
    gate <= 1'b0;
    wb(1, 8'h04, 2);
    wb(1, 8'h00, 1);
    n0 = nconv;
    repeat (20) @(posedge clk_i);
    chk(nconv - n0, 0);
    gate <= 1'b1;
    iv(c);
    chk(c, 4);
    // continuous mode ignores the total until stopped
    wb(1, 8'h00, 2);
    wb(1, 8'h04, 32'h20);
    wb(1, 8'h00, 1);
    repeat (200) @(posedge clk_i);
    chk({done_o, active_o}, 1);
    wb(1, 8'h00, 2);
    repeat (3) @(posedge clk_i);
    chk(active_o, 0);
    // pretrigger: eight total, three after the stop edge, slow answers
    slow <= 1'b1;
    wb(1, 8'h0c, 10);
    wb(1, 8'h10, 8);
    wb(1, 8'h14, 3);
    wb(1, 8'h04, 32'h10);
    n0 = nval;
    wb(1, 8'h00, 1);
    repeat (300) @(posedge clk_i);
    iv(c);
    repeat (4) @(posedge clk_i);
    stop <= 1'b1;
    stop_seen <= 1'b1;
    repeat (2) @(posedge clk_i);
    stop <= 1'b0;
    wdone();
    repeat (10) @(posedge clk_i);
    chk(npost == 3 || npost == 4, 1);
    wb(0, 8'h20, 0);
    chk(q, nval - n0);
    wb(0, 8'h1c, 0);
    q0 = q;
    for (int i = 1; i < 8; i++) begin
      wb(0, 8'h1c, 0);
      chk(q, q0 + i);
    end
    chk(q, {16'h0, last_v});
    end_of_test();
  end
endmodule
